// ==== hdl/tcc_pkg.sv ====
// Summary of operation
// - Up mode: overflow flag (bit 7) sets when counter wraps to zero after modulo.
// - Center-aligned: flag sets on the step down after reaching modulo.
// - Clear flag by reading it set, then writing 0; new overflow restarts sequence.
// - Writing 1 to the flag does nothing; reset clears the flag.
// - With interrupt enable (bit 6) set, interrupt request follows the flag.
// - Center-aligned select (bit 5): 0 counts up, 1 counts up/down, all channels.
// - Select 0: channels use their own mode bits.
// - Select 1: all channels run center-aligned PWM.
// - Clock source bits 4:3: off, bus clock, fixed system clock, external clock.
// - Fixed system clock and external clock are synchronised to the bus clock.
// - Prescale bits 2:0 divide the selected clock by two to the field value.
// - Prescaler sits after source selection and synchronisation.
// - Writing a counter byte clears the counter; reading one latches both until the other is read.
// - Reset, counter byte writes and status/control writes restart the buffer.
// - Reset clears the counter.
// - Debug mode freezes counter and buffer; counter byte reads then change nothing.
// - At modulo the counter restarts from zero or turns down; flag sets.
// - A write to one modulo byte holds off the flag until the other is written or status/control is written.
// - Reset loads modulo with zero: counter runs free over 16 bits.
package tcc_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h04;
	localparam logic [7:0] ADDR_COUNTER_LOW = 8'h08;
	localparam logic [7:0] ADDR_MODULO_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_MODULO_LOW = 8'h10;
	// ----------------------------------------------------------------
	// Status/control fields
	// ----------------------------------------------------------------
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_CENTER_SELECT = 5;
	localparam int CLKSRC_MSB = 4;
	localparam int CLKSRC_LSB = 3;
	localparam int PRESCALE_MSB = 2;
	localparam int PRESCALE_LSB = 0;
	localparam logic [1:0] CLKSRC_OFF = 2'h0;
	localparam logic [1:0] CLKSRC_BUS = 2'h1;
	localparam logic [1:0] CLKSRC_FIXED = 2'h2;
	localparam logic [1:0] CLKSRC_EXT = 2'h3;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] MODULO_RESET = 16'h0000;
	localparam logic [15:0] COUNTER_TOP = 16'hFFFF;
	localparam logic [6:0] PRESCALE_RESET = 7'h00;
	localparam logic [6:0] PRESCALE_ONE = 7'h01;
	localparam logic [31:0] READ_ZERO = 32'h00000000;
	// ----------------------------------------------------------------
	// Channel mode output encoding
	// ----------------------------------------------------------------
	localparam logic [1:0] CHMODE_OWN = 2'h0;
	localparam logic [1:0] CHMODE_CENTER = 2'h1;
	// ----------------------------------------------------------------
	// Read-coherency buffer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BUF_OPEN,
		BUF_WAIT_LOW,
		BUF_WAIT_HIGH
	} tcc_buf_state_type;
endpackage

// ==== hdl/tcc_sync.sv ====
`timescale 1ns/10ps
module tcc_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;

	// Two flops per bit; only the second flop reads the first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule // tcc_sync

// ==== hdl/tcc_prescaler.sv ====
`timescale 1ns/10ps
module tcc_prescaler #(
	parameter int DIV_BITS = 7
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Selected source tick and divide exponent
	input wire logic src_tick,
	input wire logic [2:0] prescale,
	// Counting tick, one pclk wide
	output logic count_tick
);
	logic [DIV_BITS-1:0] div_reg;
	logic [DIV_BITS-1:0] div_next;
	logic [DIV_BITS-1:0] div_mask;
	logic wrap;

	// Division by two to the field value follows whatever source is chosen.
	assign div_mask = DIV_BITS'((1 << prescale) - 1);
	assign wrap = ((div_reg & div_mask) == div_mask);
	assign div_next = wrap ? tcc_pkg::PRESCALE_RESET : div_reg + tcc_pkg::PRESCALE_ONE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= tcc_pkg::PRESCALE_RESET;
			count_tick <= 1'b0;
		end else begin
			count_tick <= src_tick && wrap;
			if (src_tick) begin
				div_reg <= div_next;
			end
		end
	end
endmodule // tcc_prescaler

// ==== hdl/tcc_core.sv ====
`timescale 1ns/10ps
module tcc_core (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock sources and debug state
	input wire logic fixed_system_clock,
	input wire logic ext_clock_in,
	input wire logic debug_active,
	// Timer outputs
	output logic overflow_irq,
	output logic [1:0] channel_mode,
	output logic [15:0] counter_value,
	output logic count_down
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic overflow_flag_reg;
	logic overflow_irq_enable_reg;
	logic center_aligned_select_reg;
	logic [1:0] clock_source_field_reg;
	logic [2:0] prescale_field_reg;
	logic [15:0] counter_reg;
	logic [15:0] modulo_value_reg;
	logic [7:0] modulo_high_buf_reg;
	logic [7:0] modulo_low_buf_reg;
	logic mod_high_written_reg;
	logic mod_low_written_reg;
	logic down_reg;
	logic clear_armed_reg;
	logic [15:0] latch_reg;
	tcc_pkg::tcc_buf_state_type buf_state_reg;
	logic [1:0] sync_level;
	logic [1:0] sync_prev_reg;
	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// The slave always answers with no wait states, so the access phase is
	// complete at the first edge on which psel and penable are both high. Side effects
	// of reads and writes happen on that edge only.
	wire access_done = psel && penable;
	wire wr = access_done && pwrite;
	wire rd = access_done && !pwrite;
	wire sel_sc = (paddr == tcc_pkg::ADDR_STATUS_CONTROL);
	wire sel_cnth = (paddr == tcc_pkg::ADDR_COUNTER_HIGH);
	wire sel_cntl = (paddr == tcc_pkg::ADDR_COUNTER_LOW);
	wire sel_modh = (paddr == tcc_pkg::ADDR_MODULO_HIGH);
	wire sel_modl = (paddr == tcc_pkg::ADDR_MODULO_LOW);
	wire mapped = sel_sc || sel_cnth || sel_cntl || sel_modh || sel_modl;
	wire wr_sc = wr && sel_sc;
	wire wr_cnt = wr && (sel_cnth || sel_cntl);
	wire rd_sc = rd && sel_sc;
	wire rd_cnth = rd && sel_cnth;
	wire rd_cntl = rd && sel_cntl;
	wire [7:0] sc_read = {overflow_flag_reg, overflow_irq_enable_reg,
		center_aligned_select_reg, clock_source_field_reg, prescale_field_reg};
	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	// Both slow sources are caught in the pclk domain before edge detection.
	tcc_sync #(.WIDTH(2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({ext_clock_in, fixed_system_clock}),
		.sync_out(sync_level)
	);
	wire [1:0] rise = sync_level & ~sync_prev_reg;
	// A slow source gives one tick per synchronised rising edge. Its high and low phases
	// must each span more than one pclk cycle, or edges can be lost in the synchroniser.
	logic src_tick;
	always_comb begin
		case (clock_source_field_reg)
			tcc_pkg::CLKSRC_BUS: src_tick = 1'b1;
			tcc_pkg::CLKSRC_FIXED: src_tick = rise[0];
			tcc_pkg::CLKSRC_EXT: src_tick = rise[1];
			default: src_tick = 1'b0;
		endcase
	end
	logic count_tick;
	tcc_prescaler #(.DIV_BITS(7)) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.src_tick(src_tick),
		.prescale(prescale_field_reg),
		.count_tick(count_tick)
	);
	// ----------------------------------------------------------------
	// Counter step and overflow
	// ----------------------------------------------------------------
	// Debug mode stops counting entirely, so no overflow can arise then.
	// Writes still reach the counter in debug mode, so software can clear it while halted.
	wire step = count_tick && !debug_active && (clock_source_field_reg != tcc_pkg::CLKSRC_OFF);
	// A zero modulo means free running over the full range. In up/down mode this leaves
	// the turn at the top of the range, which is why software should avoid it there.
	wire [15:0] top = (modulo_value_reg == tcc_pkg::MODULO_RESET) ?
		tcc_pkg::COUNTER_TOP : modulo_value_reg;
	wire at_top = (counter_reg >= top);
	wire at_zero = (counter_reg == tcc_pkg::COUNTER_RESET);
	logic [15:0] counter_next;
	logic down_next;
	logic ovf_event;
	always_comb begin
		counter_next = counter_reg;
		down_next = down_reg;
		ovf_event = 1'b0;
		if (!center_aligned_select_reg) begin
			down_next = 1'b0;
			if (at_top) begin
				counter_next = tcc_pkg::COUNTER_RESET;
				ovf_event = 1'b1;
			end else begin
				counter_next = counter_reg + 16'h0001;
			end
		end else if (down_reg) begin
			if (at_zero) begin
				down_next = 1'b0;
				counter_next = counter_reg + 16'h0001;
			end else begin
				counter_next = counter_reg - 16'h0001;
			end
		end else if (at_top) begin
			down_next = 1'b1;
			counter_next = counter_reg - 16'h0001;
			ovf_event = 1'b1;
		end else begin
			counter_next = counter_reg + 16'h0001;
		end
	end
	// Half-written modulo values suppress the flag.
	wire mod_pending = mod_high_written_reg ^ mod_low_written_reg;
	wire ovf_set = step && ovf_event && !mod_pending;
	// ----------------------------------------------------------------
	// Control register and overflow flag
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_reg <= 1'b0;
			overflow_irq_enable_reg <= 1'b0;
			center_aligned_select_reg <= 1'b0;
			clock_source_field_reg <= tcc_pkg::CONTROL_RESET[tcc_pkg::CLKSRC_MSB:tcc_pkg::CLKSRC_LSB];
			prescale_field_reg <= tcc_pkg::CONTROL_RESET[tcc_pkg::PRESCALE_MSB:tcc_pkg::PRESCALE_LSB];
			clear_armed_reg <= 1'b0;
		end else begin
			// The flag bit of the written byte is never stored; it only takes part in
			// the clear sequence below.
			if (wr_sc) begin
				overflow_irq_enable_reg <= pwdata[tcc_pkg::BIT_IRQ_ENABLE];
				center_aligned_select_reg <= pwdata[tcc_pkg::BIT_CENTER_SELECT];
				clock_source_field_reg <= pwdata[tcc_pkg::CLKSRC_MSB:tcc_pkg::CLKSRC_LSB];
				prescale_field_reg <= pwdata[tcc_pkg::PRESCALE_MSB:tcc_pkg::PRESCALE_LSB];
			end
			// A new overflow wins over a clear and disarms the sequence.
			if (ovf_set) begin
				overflow_flag_reg <= 1'b1;
				clear_armed_reg <= 1'b0;
			end else if (wr_sc && clear_armed_reg && !pwdata[tcc_pkg::BIT_OVERFLOW_FLAG]) begin
				overflow_flag_reg <= 1'b0;
				clear_armed_reg <= 1'b0;
			end else if (rd_sc && overflow_flag_reg) begin
				clear_armed_reg <= 1'b1;
			end
		end
	end
	// ----------------------------------------------------------------
	// Counter and modulo
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_reg <= tcc_pkg::COUNTER_RESET;
			down_reg <= 1'b0;
		end else if (wr_cnt) begin
			counter_reg <= tcc_pkg::COUNTER_RESET;
			down_reg <= 1'b0;
		end else if (step) begin
			counter_reg <= counter_next;
			down_reg <= down_next;
		end else if (!center_aligned_select_reg) begin
			// Leaving up/down mode drops the direction at once, not at the next count.
			down_reg <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modulo_value_reg <= tcc_pkg::MODULO_RESET;
			modulo_high_buf_reg <= 8'h00;
			modulo_low_buf_reg <= 8'h00;
			mod_high_written_reg <= 1'b0;
			mod_low_written_reg <= 1'b0;
		end else if (wr_sc) begin
			// Control writes cancel a half-written modulo.
			mod_high_written_reg <= 1'b0;
			mod_low_written_reg <= 1'b0;
		end else if (wr && sel_modh) begin
			// Both bytes wait in buffers; the live limit changes only when the pair is
			// complete, so a half-written value never moves the wrap point.
			modulo_high_buf_reg <= pwdata[7:0];
			if (mod_low_written_reg) begin
				modulo_value_reg <= {pwdata[7:0], modulo_low_buf_reg};
				mod_low_written_reg <= 1'b0;
			end else begin
				mod_high_written_reg <= 1'b1;
			end
		end else if (wr && sel_modl) begin
			modulo_low_buf_reg <= pwdata[7:0];
			if (mod_high_written_reg) begin
				modulo_value_reg <= {modulo_high_buf_reg, pwdata[7:0]};
				mod_high_written_reg <= 1'b0;
			end else begin
				mod_low_written_reg <= 1'b1;
			end
		end
	end
	// ----------------------------------------------------------------
	// Read-coherency buffer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_state_reg <= tcc_pkg::BUF_OPEN;
			latch_reg <= tcc_pkg::COUNTER_RESET;
		end else if (wr_cnt || wr_sc) begin
			buf_state_reg <= tcc_pkg::BUF_OPEN;
		end else if (!debug_active) begin
			case (buf_state_reg)
				tcc_pkg::BUF_OPEN: begin
					// While open the copy tracks the counter, so it already holds the value
					// that the leaving read returned; both halves then come from one count.
					if (rd_cnth) begin
						buf_state_reg <= tcc_pkg::BUF_WAIT_LOW;
					end else if (rd_cntl) begin
						buf_state_reg <= tcc_pkg::BUF_WAIT_HIGH;
					end else begin
						latch_reg <= counter_reg;
					end
				end
				tcc_pkg::BUF_WAIT_LOW: begin
					if (rd_cntl) begin
						buf_state_reg <= tcc_pkg::BUF_OPEN;
					end
				end
				tcc_pkg::BUF_WAIT_HIGH: begin
					if (rd_cnth) begin
						buf_state_reg <= tcc_pkg::BUF_OPEN;
					end
				end
				default: buf_state_reg <= tcc_pkg::BUF_OPEN;
			endcase
		end
	end
	// Live value when open; the latched copy once a byte has been read.
	wire [15:0] cnt_view = (buf_state_reg == tcc_pkg::BUF_OPEN) ? counter_reg : latch_reg;
	// ----------------------------------------------------------------
	// Read data and outputs
	// ----------------------------------------------------------------
	// Read data are taken in the setup cycle and held while pready stands.
	logic [31:0] rdata_next;
	always_comb begin
		rdata_next = tcc_pkg::READ_ZERO;
		if (sel_sc) begin
			rdata_next[7:0] = sc_read;
		end else if (sel_cnth) begin
			rdata_next[7:0] = cnt_view[15:8];
		end else if (sel_cntl) begin
			rdata_next[7:0] = cnt_view[7:0];
		end else if (sel_modh) begin
			rdata_next[7:0] = modulo_value_reg[15:8];
		end else if (sel_modl) begin
			rdata_next[7:0] = modulo_value_reg[7:0];
		end
	end
	// Answers take no wait state; pready is set from the setup cycle so every output comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= tcc_pkg::READ_ZERO;
			sync_prev_reg <= 2'b00;
			overflow_irq <= 1'b0;
			channel_mode <= tcc_pkg::CHMODE_OWN;
			counter_value <= tcc_pkg::COUNTER_RESET;
			count_down <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rdata_next : tcc_pkg::READ_ZERO;
			sync_prev_reg <= sync_level;
			overflow_irq <= overflow_irq_enable_reg && overflow_flag_reg;
			// Channels follow their own mode bits unless center-aligned is forced.
			channel_mode <= center_aligned_select_reg ? tcc_pkg::CHMODE_CENTER : tcc_pkg::CHMODE_OWN;
			// The counter and direction are copied out a cycle late; whoever compares
			// them must allow for that lag.
			counter_value <= counter_reg;
			count_down <= down_reg;
		end
	end
endmodule // tcc_core

// ==== testbench/tcc_core_sva.sv ====
`timescale 1ns/10ps
module tcc_core_sva (
	// APB side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Timer side
	input wire logic debug_active,
	input wire logic overflow_irq,
	input wire logic [1:0] channel_mode,
	input wire logic [15:0] counter_value,
	input wire logic count_down
);
	// ------------------------------------------------------------
	// Shadow of the control byte
	// ------------------------------------------------------------
	// The shadow lets mode checks wait until a control write has settled.
	wire acc = psel && penable && pready && pwrite;
	wire wr_sc = acc && paddr == tcc_pkg::ADDR_STATUS_CONTROL;
	wire wr_cnt = acc && (paddr == tcc_pkg::ADDR_COUNTER_HIGH || paddr == tcc_pkg::ADDR_COUNTER_LOW);
	logic [7:0] sc_sh;
	wire src_off = sc_sh[4:3] == 2'h0;
	logic [1:0] sc_age;
	logic [2:0] off_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc_sh <= 8'h00;
			sc_age <= 2'h3;
			off_cnt <= 3'h0;
		end else begin
			if (wr_sc) begin
				sc_sh <= pwdata[7:0];
			end
			sc_age <= wr_sc ? 2'h0 : (sc_age == 2'h3 ? 2'h3 : sc_age + 2'h1);
			off_cnt <= (!src_off || wr_sc || wr_cnt) ? 3'h0 : (off_cnt == 3'h7 ? 3'h7 : off_cnt + 3'h1);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_frozen;
		debug_active [*3];
	endsequence
	property p_reset_zero;
		$rose(presetn) |-> counter_value == 16'h0000 && !overflow_irq;
	endproperty
	property p_irq_fall;
		$fell(overflow_irq) |-> $past(wr_sc, 2);
	endproperty
	property p_irq_rise;
		$rose(overflow_irq) |-> sc_sh[6];
	endproperty
	property p_cnt_clear;
		wr_cnt |-> ##2 counter_value == 16'h0000;
	endproperty
	property p_debug;
		s_frozen |=> $stable(counter_value);
	endproperty
	property p_src_off;
		off_cnt == 3'h7 |-> $stable(counter_value);
	endproperty
	property p_chan_mode;
		sc_age >= 2'h2 |-> channel_mode == {1'b0, sc_sh[5]};
	endproperty
	property p_up_only;
		sc_age == 2'h3 && !sc_sh[5] |-> !count_down;
	endproperty
	property p_up_step;
		sc_age == 2'h3 && !sc_sh[5] && counter_value != $past(counter_value)
			|-> counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("counter or irq not clear after reset");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without control write");
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose while disabled");
	a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear");
	a_debug: assert property (p_debug) else $error("counter moved in debug");
	a_src_off: assert property (p_src_off) else $error("counter moved with source off");
	a_chan_mode: assert property (p_chan_mode) else $error("channel mode wrong");
	a_up_only: assert property (p_up_only) else $error("down count in up mode");
	a_up_step: assert property (p_up_step) else $error("bad up step");
endmodule // tcc_core_sva
bind tcc_core tcc_core_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.debug_active(debug_active), .overflow_irq(overflow_irq), .channel_mode(channel_mode),
	.counter_value(counter_value), .count_down(count_down));

// ==== testbench/tb_timer_counter_core_control.sv ====
`timescale 1ns/10ps
module tb_timer_counter_core_control;
	localparam logic [7:0] a_sc = tcc_pkg::ADDR_STATUS_CONTROL;
	localparam logic [7:0] a_ch = tcc_pkg::ADDR_COUNTER_HIGH;
	localparam logic [7:0] a_cl = tcc_pkg::ADDR_COUNTER_LOW;
	localparam logic [7:0] a_mh = tcc_pkg::ADDR_MODULO_HIGH;
	localparam logic [7:0] a_ml = tcc_pkg::ADDR_MODULO_LOW;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} tcc_note_type;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, overflow_irq, count_down;
	logic fixed_system_clock = 1'b0, ext_clock_in = 1'b0, debug_active = 1'b0;
	logic [1:0] channel_mode;
	logic [15:0] counter_value, v;
	tcc_note_type notes[$];
	tcc_note_type note;
	int mismatches = 0;
	int total_checks = 0;
	int n;
	always #25 pclk = ~pclk;
	tcc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fixed_system_clock(fixed_system_clock), .ext_clock_in(ext_clock_in),
		.debug_active(debug_active), .overflow_irq(overflow_irq), .channel_mode(channel_mode),
		.counter_value(counter_value), .count_down(count_down));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic sig(input string nm, input logic s, input logic e);
		check(nm, {31'h0, s}, {31'h0, e});
	endtask
	// The counter output lags the counter by a cycle, so let two edges pass first.
	task automatic cnt(input logic [15:0] e);
		repeat (2) @(posedge pclk);
		check("counter_value", {16'h0, counter_value}, {16'h0, e});
	endtask
	// ------------------------------------------------------------
	// APB master, one idle cycle between transfers
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d | ($urandom & 32'hFFFFFF00);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			mismatches++;
			results();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1,
		input logic e = 1'b0);
		notes.push_back('{d, m, e});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Edges are slow enough for the two-flop synchroniser to see each level.
	task automatic pulse(input int k, input logic fx);
		repeat (k) begin
			{fixed_system_clock, ext_clock_in} <= fx ? 2'h2 : 2'h1;
			repeat (5) @(posedge pclk);
			{fixed_system_clock, ext_clock_in} <= 2'h0;
			repeat (5) @(posedge pclk);
		end
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (notes.size() == 0) begin
				check("note queue", 32'h1, 32'h0);
			end else begin
				note = notes.pop_front();
				check("prdata", prdata & note.m, note.d & note.m);
				check("pslverr", {31'h0, pslverr}, {31'h0, note.e});
			end
		end
	end
	initial begin
		void'($urandom(46));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(a_sc, 32'h00);
		rd(a_ch, 32'h00);
		rd(a_cl, 32'h00);
		rd(8'h14, 32'h00, '1, 1'b1);
		wr(a_mh, 32'h00);
		wr(a_ml, 32'h03);
		wr(a_sc, 32'h98);
		rd(a_sc, 32'h18);
		pulse(3, 1'b0);
		cnt(16'h0003);
		rd(a_sc, 32'h18);
		pulse(1, 1'b0);
		cnt(16'h0000);
		rd(a_sc, 32'h98);
		wr(a_sc, 32'hD8);
		rd(a_sc, 32'hD8);
		sig("overflow_irq", overflow_irq, 1'b1);
		pulse(4, 1'b0);
		wr(a_sc, 32'h58);
		rd(a_sc, 32'hD8);
		wr(a_sc, 32'h58);
		rd(a_sc, 32'h58);
		sig("overflow_irq", overflow_irq, 1'b0);
		wr(a_mh, 32'h00);
		pulse(4, 1'b0);
		rd(a_sc, 32'h58);
		wr(a_ml, 32'h05);
		pulse(6, 1'b0);
		rd(a_sc, 32'hD8);
		wr(a_sc, 32'h90);
		repeat (2) @(posedge pclk);
		sig("overflow_irq", overflow_irq, 1'b0);
		wr(a_ml, 32'h00);
		wr(a_mh, 32'h00);
		pulse(5, 1'b1);
		wr(a_ch, 32'hFF);
		cnt(16'h0000);
		rd(a_ch, 32'h00);
		rd(a_cl, 32'h00);
		pulse(258, 1'b1);
		cnt(16'h0102);
		rd(a_ch, 32'h01);
		pulse(3, 1'b1);
		rd(a_cl, 32'h02);
		rd(a_cl, 32'h05);
		rd(a_ch, 32'h01);
		pulse(1, 1'b1);
		rd(a_ch, 32'h01);
		wr(a_sc, 32'h90);
		pulse(1, 1'b1);
		rd(a_cl, 32'h07);
		rd(a_ch, 32'h01);
		rd(a_ch, 32'h01);
		debug_active <= 1'b1;
		pulse(2, 1'b1);
		cnt(16'h0107);
		rd(a_cl, 32'h07);
		debug_active <= 1'b0;
		pulse(2, 1'b1);
		rd(a_cl, 32'h07);
		cnt(16'h0109);
		wr(a_sc, 32'h80);
		pulse(3, 1'b1);
		cnt(16'h0109);
		for (int p = 0; p < 8; p++) begin
			wr(a_sc, 32'h98 | p);
			v = counter_value;
			n = 0;
			while (counter_value === v && n < 300) begin
				pulse(1, 1'b0);
				n++;
			end
			check("prescale sync", {31'h0, n >= 300}, 32'h0);
			v = counter_value;
			pulse((1 << p) - 1, 1'b0);
			cnt(v);
			pulse(1, 1'b0);
			cnt(v + 16'h0001);
		end
		rd(a_sc, 32'h9F);
		wr(a_sc, 32'h38);
		rd(a_sc, 32'h38);
		wr(a_mh, 32'h00);
		wr(a_ml, 32'h04);
		wr(a_cl, 32'h00);
		check("channel_mode", {30'h0, channel_mode}, 32'h1);
		pulse(4, 1'b0);
		rd(a_sc, 32'h38);
		pulse(1, 1'b0);
		cnt(16'h0003);
		rd(a_sc, 32'hB8);
		sig("count_down", count_down, 1'b1);
		pulse(4, 1'b0);
		cnt(16'h0001);
		wr(a_sc, 32'h18);
		repeat (2) @(posedge pclk);
		check("channel_mode", {30'h0, channel_mode}, 32'h0);
		results();
	end
endmodule // tb_timer_counter_core_control
